// >>> pkg/eeprom_pkg.sv
// Functional notes
// (R1) Type nibble 1010 selects main array
// (R2) Type nibble 1011 selects serial-number block
// (R3) Address bit 3 must match select strap
// (R4) Unstrapped package: controller sends zero there
// (R5) Address bits 2:1 are location bits 9:8
// (R6) Address bit 0: one reads, zero writes
// (R7) Ack matching address byte, else leave high
// (R8) Controller sends low location byte next
// (R9) Write: start, address, location, data bytes
// (R10) Byte write acks address, location, data
// (R11) Stop launches self-timed programming cycle
// (R12) Busy programming: ignore bus, no response
// (R13) Page write stores up to 16 row bytes
// (R14) Partial pages program only received bytes
// (R15) Page write: ack each of sixteen bytes
// (R16) Only low four location bits advance
// (R17) In-row location wraps to row start
// (R18) Controller should avoid row wrap overwrite
// (R19) Busy: withhold ack from write address
// (R20) Controller may poll with write address
// (R21) Attempts before cycle end not processed
// (R22) Write protect: ack all, never program
// (R23) Serial block location top bits are 10
// (R24) Buffer page, commit at stop, discard otherwise
// (R25) After nack ignore bus until start
// (R26) Serial-block writes acked, never programmed
`default_nettype none
package eeprom_pkg;
  localparam logic [3:0] ID_ARRAY   = 4'hA;
  localparam logic [3:0] ID_SERIAL  = 4'hB;
  localparam int unsigned ID_MSB    = 7;
  localparam int unsigned ID_LSB    = 4;
  localparam int unsigned STRAP_BIT = 3;
  localparam int unsigned HI_MSB    = 2;
  localparam int unsigned HI_LSB    = 1;
  localparam int unsigned DIR_BIT   = 0;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned LOC_W     = 10;
  localparam int unsigned ROW_LSB   = 4;
  localparam int unsigned WORD_W    = LOC_W + 8;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [9:0]  LOC_RST   = 10'h000;
  // Programming time and clock rate
  localparam int unsigned T_WR_US     = 5000;
  localparam int unsigned CLK_FREQ_KHZ = 10000;
  // Longest time: rounds down
  localparam int unsigned WR_CYCLES = T_WR_US * CLK_FREQ_KHZ / 1000;
  typedef enum logic [2:0] {PH_IDLE, PH_DEV, PH_WORD, PH_DATA, PH_SKIP} phase_t;
endpackage
`default_nettype wire

// >>> logic/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk_i,  // Block clock
  input  wire logic         rst_i,  // Sync reset
  input  wire logic         ce_i,   // Clock enable
  input  wire logic [W-1:0] d_i,    // Asynchronous levels
  output logic      [W-1:0] q_o     // Synchronised levels
);
  logic [W-1:0] meta_reg;

  // Two stages; only the second stage is read outside.
  // Reset to ones: bus lines idle high, so no false edge follows
  // reset; a protect pin then reads as set, the safe side.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '1;
      q_o      <= '1;
    end else if (ce_i) begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> logic/skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module skid_buf #(
  parameter int unsigned W = 18
) (
  input  wire logic         clk_i,      // Block clock
  input  wire logic         rst_i,      // Sync reset
  input  wire logic         ce_i,       // Clock enable
  input  wire logic         in_valid_i, // Word offered
  output logic              in_ready_o, // Room for a word
  input  wire logic [W-1:0] in_data_i,  // Offered word
  output logic              out_valid_o,// Word held at output
  input  wire logic         out_ready_i,// Sink takes word
  output logic      [W-1:0] out_data_o  // Held word
);
  logic [W-1:0] skid_reg;
  logic         in_fire;

  assign in_fire = in_valid_i & in_ready_o;

  // Two entries: output stage plus a skid stage, all from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      skid_reg    <= '0;
      in_ready_o  <= 1'b1;
    end else if (ce_i) begin
      if (!out_valid_o || out_ready_i) begin
        if (!in_ready_o) begin
          out_data_o  <= skid_reg;
          out_valid_o <= 1'b1;
          in_ready_o  <= 1'b1;
        end else begin
          out_valid_o <= in_fire;
          out_data_o  <= in_data_i;
        end
      end else if (in_fire) begin
        skid_reg   <= in_data_i;
        in_ready_o <= 1'b0;  // Stall source until sink drains
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/eeprom_write_target.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_target #(
  parameter int unsigned WR_CYCLES = eeprom_pkg::WR_CYCLES
) (
  input  wire logic       clk_i,              // Block clock, 10 MHz
  input  wire logic       rst_i,              // Sync reset, high
  input  wire logic       ce_i,               // Clock enable
  input  wire logic       scl_i,              // Bus clock pin
  input  wire logic       sda_i,              // Bus data pin level
  output logic            sda_o,              // Data drive level, always 0
  output logic            sda_oe_o,           // Data pull-low enable
  input  wire logic       wp_i,               // Write protect pin
  input  wire logic       strap_select_bit_i, // Select strap pin
  output logic            busy_o,             // Programming cycle running
  output logic            mem_wr_valid_o,     // Array write offered
  input  wire logic       mem_wr_ready_i,     // Array takes write
  output logic [9:0]      mem_wr_addr_o,      // Array location
  output logic [7:0]      mem_wr_data_o       // Array byte
);
  localparam int unsigned PW = eeprom_pkg::PAGE_BYTES;
  localparam int unsigned WW = eeprom_pkg::WORD_W;
  // Last timer value; the busy spell may end once it is reached
  localparam logic [15:0] WR_LAST = 16'(WR_CYCLES - 1);

  // Address byte fields hit this device's identity
  function automatic logic id_hit(input logic [7:0] b, input logic strap);
    logic [3:0] id;
    id = b[eeprom_pkg::ID_MSB:eeprom_pkg::ID_LSB];
    id_hit = (id == eeprom_pkg::ID_ARRAY || id == eeprom_pkg::ID_SERIAL)
             && (b[eeprom_pkg::STRAP_BIT] == strap);
  endfunction

  // Phase that carries data bytes into the page
  function automatic logic is_data(input eeprom_pkg::phase_t p);
    is_data = (p == eeprom_pkg::PH_DATA);
  endfunction

  // Phases in which the data line stays released
  function automatic logic is_quiet(input eeprom_pkg::phase_t p);
    is_quiet = (p == eeprom_pkg::PH_IDLE || p == eeprom_pkg::PH_SKIP);
  endfunction

  logic [3:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic       strap_s;
  logic       scl_q;
  logic       sda_q;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;

  eeprom_pkg::phase_t phase_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        ack_phase_reg;
  logic        serial_reg;
  logic [9:0]  loc_reg;
  logic [7:0]  page_data_reg [PW];
  logic [15:0] page_mask_reg;
  logic [5:0]  row_reg;
  logic        commit_reg;
  logic [3:0]  idx_reg;
  logic [15:0] timer_reg;

  logic        byte_done;
  logic        ack_now;
  logic        store;
  logic        launch;
  logic        push;
  logic        advance;
  logic        buf_ready;
  logic [WW-1:0] buf_word;

  // Pins are asynchronous to the block clock.
  // Strap and protect are static in use, but they share the
  // synchroniser so every pin sees the same latency.
  bit_sync #(.W(4)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({scl_i, sda_i, wp_i, strap_select_bit_i}),
    .q_o   (pins_s)
  );
  assign {scl_s, sda_s, wp_s, strap_s} = pins_s;

  // Previous levels for edge and condition detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_i) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Start and stop are data edges while the bus clock stays high.
  // Both levels arrive two flops late, so a condition is seen about
  // three block clocks after the pins move; each bus level must
  // therefore last at least three block clocks.
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;

  // Eighth bit has been taken and the bus clock just fell
  assign byte_done = scl_fall && bit_cnt_reg == eeprom_pkg::BYTE_BITS
                     && !ack_phase_reg;

  // Ack decision per byte; nothing is answered while programming.
  // Read addresses are acked too, but no read data is served here.
  always_comb begin
    ack_now = 1'b0;
    case (phase_reg)
      eeprom_pkg::PH_DEV:
        ack_now = id_hit(shift_reg, strap_s) && !busy_o; // R1 R2 R3 R7 R12 R19 R21
      eeprom_pkg::PH_WORD:
        ack_now = 1'b1;  // R10
      eeprom_pkg::PH_DATA:
        ack_now = 1'b1;  // R10 R15 R22 R26
      default:
        ack_now = 1'b0;
    endcase
  end

  assign store = byte_done && is_data(phase_reg);

  // Byte engine: shifts bits, places acks, walks the phases.
  // A stop inside a byte leaves the bit count behind; the next
  // start clears it before any bit is taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg     <= eeprom_pkg::PH_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ack_phase_reg <= 1'b0;
      sda_oe_o      <= 1'b0;
      serial_reg    <= 1'b0;
      loc_reg       <= eeprom_pkg::LOC_RST;
    end else if (ce_i) begin
      if (start_det) begin
        // A start always resynchronises, even mid-byte
        phase_reg     <= eeprom_pkg::PH_DEV;
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        sda_oe_o      <= 1'b0;
      end else if (stop_det) begin
        phase_reg     <= eeprom_pkg::PH_IDLE;
        ack_phase_reg <= 1'b0;
        sda_oe_o      <= 1'b0;
      end else if (is_quiet(phase_reg)) begin
        sda_oe_o <= 1'b0;  // R25
      end else if (scl_rise && bit_cnt_reg != eeprom_pkg::BYTE_BITS) begin
        shift_reg   <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (byte_done) begin
        ack_phase_reg <= 1'b1;
        sda_oe_o      <= ack_now;  // R7
        if (!ack_now) begin
          phase_reg <= eeprom_pkg::PH_SKIP;  // R25
        end else begin
          case (phase_reg)
            eeprom_pkg::PH_DEV: begin
              serial_reg <= shift_reg[eeprom_pkg::ID_MSB:eeprom_pkg::ID_LSB]
                            == eeprom_pkg::ID_SERIAL;  // R2
              loc_reg[9:8] <= shift_reg[eeprom_pkg::HI_MSB:eeprom_pkg::HI_LSB]; // R5
            end
            eeprom_pkg::PH_WORD:
              loc_reg[7:0] <= shift_reg;  // R8
            eeprom_pkg::PH_DATA:
              loc_reg[3:0] <= loc_reg[3:0] + 4'h1;  // R16 R17
            default:
              loc_reg <= loc_reg;
          endcase
        end
      end else if (scl_fall && ack_phase_reg) begin
        // End of the ninth clock: release and pick the next phase
        ack_phase_reg <= 1'b0;
        sda_oe_o      <= 1'b0;
        bit_cnt_reg   <= 4'h0;
        case (phase_reg)
          eeprom_pkg::PH_DEV:
            // Reads are not served here; the bus is left alone
            phase_reg <= shift_reg[eeprom_pkg::DIR_BIT]
                         ? eeprom_pkg::PH_SKIP : eeprom_pkg::PH_WORD; // R6 R9
          eeprom_pkg::PH_WORD:
            phase_reg <= eeprom_pkg::PH_DATA;
          eeprom_pkg::PH_DATA:
            phase_reg <= eeprom_pkg::PH_DATA;  // R15
          default:
            phase_reg <= eeprom_pkg::PH_SKIP;
        endcase
      end
    end
  end

  // Row-wide holding buffer, one byte per in-row location.
  // Bytes stay in place between transactions; only the mask says
  // which of them belong to the pending page.
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_page
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          page_data_reg[gi] <= 8'h00;
        end else if (ce_i && store && loc_reg[3:0] == 4'(gi)) begin
          page_data_reg[gi] <= shift_reg;  // R13 R24
        end
      end
    end
  endgenerate

  // Program only when something valid was written to the array
  assign launch = stop_det && is_data(phase_reg)
                  && page_mask_reg != eeprom_pkg::MASK_RST
                  && !wp_s && !serial_reg && !busy_o;  // R11 R22 R26

  assign push    = commit_reg && page_mask_reg[idx_reg];
  assign advance = commit_reg && (!page_mask_reg[idx_reg] || buf_ready);

  // Received-byte mask; a start outside programming drops the page.
  // A polling start during programming must not drop the page that
  // is still streaming out to the array.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_mask_reg <= eeprom_pkg::MASK_RST;
    end else if (ce_i) begin
      if (push && buf_ready) begin
        page_mask_reg[idx_reg] <= 1'b0;
      end else if (start_det && !busy_o) begin
        page_mask_reg <= eeprom_pkg::MASK_RST;  // R24
      end else if (stop_det && !launch && !busy_o) begin
        page_mask_reg <= eeprom_pkg::MASK_RST;  // R22 R26
      end else if (store) begin
        page_mask_reg[loc_reg[3:0]] <= 1'b1;  // R14
      end
    end
  end

  // Programming cycle: stream the page out, then hold busy for the cycle time.
  // The timer starts only after the page has left, so a slow array
  // lengthens the busy spell instead of cutting it short.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o     <= 1'b0;
      commit_reg <= 1'b0;
      idx_reg    <= 4'h0;
      row_reg    <= 6'h00;
      timer_reg  <= 16'h0000;
    end else if (ce_i) begin
      if (launch) begin
        busy_o     <= 1'b1;  // R11
        commit_reg <= 1'b1;
        idx_reg    <= 4'h0;
        row_reg    <= loc_reg[9:eeprom_pkg::ROW_LSB];  // R13
        timer_reg  <= 16'h0000;
      end else if (advance) begin
        idx_reg <= idx_reg + 4'h1;
        if (idx_reg == 4'(PW - 1)) begin
          commit_reg <= 1'b0;
        end
      end else if (busy_o && !commit_reg) begin
        // Waiting for the last array write keeps a stalled sink safe
        if (timer_reg >= WR_LAST && !mem_wr_valid_o) begin
          busy_o <= 1'b0;  // R12 R21
        end else if (timer_reg < WR_LAST) begin
          timer_reg <= timer_reg + 16'h0001;
        end
      end
    end
  end

  assign buf_word = {row_reg, idx_reg, page_data_reg[idx_reg]};

  // Two-entry buffer so a stalled array loses no byte.
  // Trade-off: one extra stage of flops buys a registered ready,
  // so the array's ready never reaches the page index logic
  // within the same cycle.
  skid_buf #(.W(WW)) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   (buf_word),
    .out_valid_o (mem_wr_valid_o),
    .out_ready_i (mem_wr_ready_i),
    .out_data_o  ({mem_wr_addr_o, mem_wr_data_o})
  );

  // Open-drain: the driven level is always low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else if (ce_i) begin
      sda_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> test/eeprom_write_props.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_props #(
  parameter int unsigned WR_CYCLES = 20
) (
  input  wire logic       clk_i,          // Block clock
  input  wire logic       rst_i,          // Sync reset
  input  wire logic       scl_i,          // Bus clock pin
  input  wire logic       sda_o,          // Drive level
  input  wire logic       sda_oe_o,       // Pull-low enable
  input  wire logic       busy_o,         // Programming
  input  wire logic       mem_wr_valid_o, // Write offered
  input  wire logic       mem_wr_ready_i, // Write taken
  input  wire logic [9:0] mem_wr_addr_o,  // Location
  input  wire logic [7:0] mem_wr_data_o   // Byte
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned busy_cnt;
  // Length of the busy spell, saturating so a long sink stall cannot wrap it
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      busy_cnt <= 0;
    end else if (busy_cnt < WR_CYCLES) begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  // A word taken, then another offered in the next cycle
  sequence took_word;
    mem_wr_valid_o && mem_wr_ready_i;
  endsequence
  sequence next_word;
    took_word ##1 mem_wr_valid_o;
  endsequence
  chk_drive_low: assert property (sda_o == 1'b0)
    else $error("data drive level not low");
  chk_busy_no_ack: assert property ($rose(sda_oe_o) |-> !busy_o)
    else $error("ack given while programming");
  chk_ack_after_fall: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("ack not launched in clock low");
  chk_ack_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6])
    else $error("ack released too early");
  chk_word_held: assert property (mem_wr_valid_o && !mem_wr_ready_i |=>
    mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o))
    else $error("offered word changed before taken");
  chk_word_in_busy: assert property (mem_wr_valid_o |-> busy_o)
    else $error("array write outside programming");
  chk_same_row: assert property (next_word |->
    mem_wr_addr_o[9:4] == $past(mem_wr_addr_o[9:4]))
    else $error("page words left the row");
  chk_idx_rising: assert property (next_word |->
    mem_wr_addr_o[3:0] > $past(mem_wr_addr_o[3:0]))
    else $error("in-row order not ascending");
  chk_busy_length: assert property ($fell(busy_o) |-> busy_cnt >= WR_CYCLES - 1)
    else $error("programming cycle too short");
endmodule
bind eeprom_write_target eeprom_write_props #(.WR_CYCLES(WR_CYCLES)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .busy_o(busy_o), .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
  .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o));
`default_nettype wire

// >>> test/bus_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_controller_model (
  input  wire logic clk_i,    // Paces the bus
  input  wire logic sda_oe_i, // Target pulls data low
  output logic      scl_o,    // Bus clock, high when idle
  output logic      sda_o     // Resolved data wire
);
  logic drv = 1'b1;
  // Pull-up on the wire: released means high, never the last value
  assign sda_o = drv & ~sda_oe_i;
  initial scl_o = 1'b1;
  // One quarter of the 800 ns bus period
  task automatic q(input int n);
    repeat (2 * n) @(negedge clk_i);
  endtask
  // Data is raised while the clock is still low, so this also serves as repeated start
  task automatic start_c();
    drv = 1'b1;
    q(1);
    scl_o = 1'b1;
    q(2);
    drv = 1'b0;
    q(2);
    scl_o = 1'b0;
    q(1);
  endtask
  task automatic stop_c();
    drv = 1'b0;
    q(1);
    scl_o = 1'b1;
    q(2);
    drv = 1'b1;
    q(2);
  endtask
  // Byte sent top bit first, then data released for the ninth clock
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv = b[i];
      q(1);
      scl_o = 1'b1;
      q(2);
      scl_o = 1'b0;
      q(1);
    end
    drv = 1'b1;
    q(1);
    scl_o = 1'b1;
    q(1);
    ack = ~sda_o;
    q(1);
    scl_o = 1'b0;
    q(1);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned WRC = 200;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       wp = 1'b0;
  logic       strap = 1'b1;
  logic       ready = 1'b1;
  logic       scl, sda, oe, drv0, busy, valid, ack;
  logic [9:0] addr;
  logic [7:0] data;
  logic [9:0] qa[$];
  logic [7:0] qd[$];
  int         fails = 0;
  int         checks = 0;
  int         cyc = 0;
  always #50 clk_i = ~clk_i;
  eeprom_write_target #(.WR_CYCLES(WRC)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
    .sda_o(drv0), .sda_oe_o(oe), .wp_i(wp), .strap_select_bit_i(strap),
    .busy_o(busy), .mem_wr_valid_o(valid), .mem_wr_ready_i(ready),
    .mem_wr_addr_o(addr), .mem_wr_data_o(data));
  bus_controller_model ctl (.clk_i(clk_i), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));
  // Sink stalls one cycle in four, so held words must survive a stall
  always @(negedge clk_i) ready <= (cyc % 4) != 3;
  // Capture of array writes, and the hang limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (valid && ready) begin
      qa.push_back(addr);
      qd.push_back(data);
    end
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    ctl.put_byte(b, ack);
    chk(16'(ack), 16'(exp_ack));
  endtask
  // Full single-byte write; busy is judged once the Stop has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] l, input logic [7:0] d,
                    input logic exp_busy);
    ctl.start_c();
    send(a, 1'b1);
    send(l, 1'b1);
    send(d, 1'b1);
    ctl.stop_c();
    chk(16'(busy), 16'(exp_busy));
    chk(16'(drv0), 16'h0000);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(busy), 16'h0000);
  endtask
  task automatic s_byte_poll();
    int n;
    qa.delete();
    qd.delete();
    wr(8'hAC, 8'hA5, 8'h5C, 1'b1);
    ctl.start_c();
    send(8'hAC, 1'b0);
    n = 0;
    do begin
      ctl.start_c();
      ctl.put_byte(8'hAC, ack);
      n++;
    end while (!ack && n < 20);
    chk(16'(ack), 16'h0001);
    ctl.stop_c();
    chk(16'(busy), 16'h0000);
    chk(16'(qa.size()), 16'h0001);
    chk(16'(qa[0]), 16'h02A5);
    chk(16'(qd[0]), 16'h005C);
  endtask
  task automatic s_page_wrap();
    int k;
    qa.delete();
    qd.delete();
    ctl.start_c();
    send(8'hAA, 1'b1);
    send(8'hB3, 1'b1);
    for (int i = 0; i < 17; i++) send(8'h40 + 8'(i), 1'b1);
    ctl.stop_c();
    wait_idle();
    chk(16'(qa.size()), 16'h0010);
    for (int i = 0; i < 16; i++) begin
      k = (i == 3) ? 16 : (i + 13) % 16;
      chk(16'(qa[i]), 16'h01B0 + 16'(i));
      chk(16'(qd[i]), 16'h0040 + 16'(k));
    end
  endtask
  task automatic s_refuse();
    qa.delete();
    ctl.start_c();
    send(8'h9C, 1'b0);
    send(8'hAC, 1'b0);
    ctl.start_c();
    send(8'hA4, 1'b0);
    ctl.start_c();
    send(8'hAD, 1'b1);
    ctl.stop_c();
    chk(16'(busy), 16'h0000);
    wr(8'hB8, 8'h80, 8'h11, 1'b0);
    wp = 1'b1;
    wr(8'hAC, 8'h10, 8'h33, 1'b0);
    wp = 1'b0;
    chk(16'(qa.size()), 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    s_byte_poll();
    wait_idle();
    s_page_wrap();
    s_refuse();
    report_and_stop();
  end
endmodule
`default_nettype wire
